// file: design/msd_params.svh
`ifndef MSD_PARAMS_SVH
`define MSD_PARAMS_SVH

// Address space
`define MSD_PRG_AW 16
`define MSD_XADDR_W 24
`define MSD_DIR_AW 8
`define MSD_SPECIAL_AW 7
`define MSD_DATA_W 8
`define MSD_SPACE_TOP 17'h10000
`define MSD_SPECIAL_BASE 8'h80
`define MSD_EXT_BASE_SHIFT 9

// Size codes used while the sizes are fixed at build time
`define MSD_ROM_CODE_DEF 3'h6
`define MSD_RAM_CODE_DEF 3'h3

// Wishbone register offsets
`define MSD_OFS_WAIT 8'h00
`define MSD_OFS_PTR_EXT 8'h04
`define MSD_OFS_STATUS 8'h08

// Field positions and reset values
`define MSD_WS_PRG_LSB 0
`define MSD_WS_XD_LSB 4
`define MSD_WS_W 3
`define MSD_WS_RST 3'h0
`define MSD_PTR_EXT_RST 8'h00

`endif

// file: design/msd_pkg.sv
package msd_pkg;

    typedef enum logic [1:0] {
        MSD_REG_ROM = 2'h0,
        MSD_REG_RAM = 2'h1,
        MSD_REG_EXT = 2'h2
    } msd_region_t;

    typedef enum logic [2:0] {
        MSD_ST_IDLE = 3'b001,
        MSD_ST_WAIT = 3'b010,
        MSD_ST_DONE = 3'b100
    } msd_state_t;

endpackage

// file: design/msd_wait_cnt.sv
`timescale 1ns/1ps
`default_nettype none
`include "msd_params.svh"

module msd_wait_cnt #(
    parameter int W = 4
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic load_i,
    input wire logic [W-1:0] len_i,
    output logic expired_o
);
    logic [W-1:0] cnt_reg;
    logic [W-1:0] cnt_next;

    assign cnt_next = load_i ? len_i : (cnt_reg != '0) ? cnt_reg - 1'b1 : cnt_reg;
    assign expired_o = (cnt_reg == '0);

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            cnt_reg <= '0;
        else
            cnt_reg <= cnt_next;
    end
endmodule

`default_nettype wire

// file: design/msd_region.sv
`timescale 1ns/1ps
`default_nettype none
`include "msd_params.svh"

module msd_region
    import msd_pkg::*;
(
    input wire logic [`MSD_PRG_AW-1:0] addr_i,
    input wire logic [2:0] rom_code_i,
    input wire logic [2:0] ram_code_i,
    output msd_region_t region_o
);
    logic [16:0] rom_extent;
    logic [16:0] ram_extent;
    logic [16:0] ram_start;
    logic [16:0] addr_wide;

    // Code 0 is no memory, codes 1..7 are 1 kB .. 64 kB
    assign rom_extent = (rom_code_i == 3'h0) ? 17'h00000 :
                        (17'h00001 << (`MSD_EXT_BASE_SHIFT + rom_code_i));
    assign ram_extent = (ram_code_i == 3'h0) ? 17'h00000 :
                        (17'h00001 << (`MSD_EXT_BASE_SHIFT + ram_code_i));
    assign ram_start = `MSD_SPACE_TOP - ram_extent;
    assign addr_wide = {1'b0, addr_i};

    assign region_o = (addr_wide < rom_extent) ? MSD_REG_ROM :       // R1 R19
                      (addr_wide >= ram_start) ? MSD_REG_RAM :       // R2
                      MSD_REG_EXT;                                   // R3
endmodule

`default_nettype wire

// file: design/msd_decoder.sv
// Behaviour
// R1 - Program addresses below the ROM extent go to internal program ROM.
// R2 - Program addresses in the top region up to FFFFh go to internal RAM.
// R3 - Program addresses between ROM and RAM regions go to external memory.
// R4 - Program addresses are 16 bits wide, a 64 kB space.
// R5 - Direct addresses below 80h reach the 256-byte synchronous data RAM.
// R6 - External data address takes its upper byte from the pointer extension.
// R7 - User special registers sit at 80h..FFh where no core register lives.
// R8 - While memory is not ready, the core is held stalled.
// R9 - Software sets program fetch wait states.
// R10 - Software sets external data wait states separately.
// R11 - Program memory writes use their own strobes.
// R12 - Internal program memory may be synchronous or asynchronous.
// R13 - ROM and RAM sizes are fixed at build time or taken from pins.
// R14 - Address and data buses are separate, never multiplexed.
// R15 - External memory signals completion on the ready input.
// R16 - External memories see a 24-bit address.
// R17 - User special registers use a 7-bit address with read and write enables.
// R18 - Surrounding logic supplies 3-bit ROM and RAM size codes.
// R19 - Overlapping regions resolve in favour of internal ROM.
`timescale 1ns/1ps
`default_nettype none
`include "msd_params.svh"

module msd_decoder
    import msd_pkg::*;
#(
    parameter bit PRG_SYNC = 1'b1,
    parameter bit FIXED_SIZE = 1'b0
) (
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Core program channel
    input wire logic prg_req_i,
    input wire logic prg_we_i,
    input wire logic [`MSD_PRG_AW-1:0] prg_addr_i,
    input wire logic [`MSD_DATA_W-1:0] prg_wdata_i,
    // Core external data channel
    input wire logic xd_req_i,
    input wire logic xd_we_i,
    input wire logic [15:0] xd_addr_i,
    input wire logic [`MSD_DATA_W-1:0] xd_wdata_i,
    output logic acc_ack_o,
    output logic [`MSD_DATA_W-1:0] acc_rdata_o,
    output logic stall_o,
    // Core direct space channel
    input wire logic dir_re_i,
    input wire logic dir_we_i,
    input wire logic [`MSD_DIR_AW-1:0] dir_addr_i,
    input wire logic [`MSD_DATA_W-1:0] dir_wdata_i,
    input wire logic core_reg_hit_i,
    // Size codes
    input wire logic [2:0] rom_size_code_i,
    input wire logic [2:0] ram_size_code_i,
    // Memory side
    input wire logic [`MSD_DATA_W-1:0] prgromdata_i,
    input wire logic [`MSD_DATA_W-1:0] prgramdata_i,
    input wire logic [`MSD_DATA_W-1:0] xdatai_i,
    input wire logic ready_i,
    output logic [`MSD_PRG_AW-1:0] prgaddr_o,
    output logic [`MSD_DATA_W-1:0] prgdatao_o,
    output logic prgromrd_o,
    output logic prgramrd_o,
    output logic prgramwr_o,
    output logic [`MSD_XADDR_W-1:0] xaddr_o,
    output logic [`MSD_DATA_W-1:0] xdatao_o,
    output logic xprgrd_o,
    output logic xprgwr_o,
    output logic xramrd_o,
    output logic xramwr_o,
    output logic [`MSD_DIR_AW-1:0] ramaddr_o,
    output logic [`MSD_DATA_W-1:0] ramdatao_o,
    output logic ramoe_o,
    output logic ramwe_o,
    output logic [`MSD_SPECIAL_AW-1:0] sfraddr_o,
    output logic [`MSD_DATA_W-1:0] sfrdatao_o,
    output logic sfroe_o,
    output logic sfrwe_o
);

    // ****************************************
    // Register file
    // ****************************************
    logic [`MSD_WS_W-1:0] ws_prg_reg;
    logic [`MSD_WS_W-1:0] ws_xd_reg;
    logic [7:0] data_pointer_extension_reg;
    logic wb_ack_reg;
    logic [31:0] wb_dat_reg;
    logic [31:0] rd_mux;
    logic wb_hit;
    logic wb_wr;
    logic sel_wait;
    logic sel_ptr_ext;
    logic sel_status;

    assign wb_hit = wb_cyc_i & wb_stb_i & ~wb_ack_reg;
    assign wb_wr = wb_hit & wb_we_i & wb_sel_i[0];
    assign sel_wait = (wb_adr_i == `MSD_OFS_WAIT);
    assign sel_ptr_ext = (wb_adr_i == `MSD_OFS_PTR_EXT);
    assign sel_status = (wb_adr_i == `MSD_OFS_STATUS);

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ws_prg_reg <= `MSD_WS_RST;
            ws_xd_reg <= `MSD_WS_RST;
            data_pointer_extension_reg <= `MSD_PTR_EXT_RST;
        end
        else if (wb_wr)
        begin
            if (sel_wait)
            begin
                ws_prg_reg <= wb_dat_i[`MSD_WS_PRG_LSB +: `MSD_WS_W]; // R9
                ws_xd_reg <= wb_dat_i[`MSD_WS_XD_LSB +: `MSD_WS_W];   // R10
            end
            if (sel_ptr_ext)
                data_pointer_extension_reg <= wb_dat_i[7:0];
        end
    end

    // ****************************************
    // Access sequencer declarations
    // ****************************************
    msd_state_t state_reg;
    msd_state_t state_next;
    msd_region_t region_now;
    msd_region_t region_reg;
    logic is_xd_reg;
    logic is_we_reg;
    logic [2:0] rom_code;
    logic [2:0] ram_code;
    logic start_prg;
    logic start_xd;
    logic start;
    logic internal_now;
    logic [3:0] wait_len;
    logic wait_expired;
    logic finish;
    logic [`MSD_DATA_W-1:0] rdata_sel;

    assign rd_mux = sel_wait ? {25'h0, ws_xd_reg, 1'b0, ws_prg_reg} :
                    sel_ptr_ext ? {24'h0, data_pointer_extension_reg} :
                    sel_status ? {25'h0, ram_code, rom_code, state_reg != MSD_ST_IDLE} :
                    32'h0;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wb_ack_reg <= 1'b0;
            wb_dat_reg <= 32'h0;
        end
        else
        begin
            wb_ack_reg <= wb_hit;
            wb_dat_reg <= wb_hit ? rd_mux : wb_dat_reg;
        end
    end

    assign wb_ack_o = wb_ack_reg;
    assign wb_dat_o = wb_dat_reg;

    // ****************************************
    // Program region decode
    // ****************************************
    assign rom_code = FIXED_SIZE ? `MSD_ROM_CODE_DEF : rom_size_code_i; // R13 R18
    assign ram_code = FIXED_SIZE ? `MSD_RAM_CODE_DEF : ram_size_code_i; // R13 R18

    msd_region u_region (
        .addr_i(prg_addr_i),
        .rom_code_i(rom_code),
        .ram_code_i(ram_code),
        .region_o(region_now)
    );

    // ****************************************
    // Access sequencer
    // ****************************************
    assign start_prg = (state_reg == MSD_ST_IDLE) & prg_req_i;
    assign start_xd = (state_reg == MSD_ST_IDLE) & ~prg_req_i & xd_req_i;
    assign start = start_prg | start_xd;
    assign internal_now = start_prg & (region_now != MSD_REG_EXT);

    // Synchronous memory needs one more cycle for its registered output
    assign wait_len = start_prg ?
                      ({1'b0, ws_prg_reg} + {3'h0, PRG_SYNC & internal_now}) : // R9 R12
                      {1'b0, ws_xd_reg};                                        // R10

    msd_wait_cnt #(
        .W(4)
    ) u_wait (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .load_i(start),
        .len_i(wait_len),
        .expired_o(wait_expired)
    );

    // Internal program memory ignores ready
    assign finish = (state_reg == MSD_ST_WAIT) & wait_expired &
                    (ready_i | (~is_xd_reg & region_reg != MSD_REG_EXT)); // R8 R15

    assign rdata_sel = is_xd_reg ? xdatai_i :
                       (region_reg == MSD_REG_ROM) ? prgromdata_i :
                       (region_reg == MSD_REG_RAM) ? prgramdata_i :
                       xdatai_i;

    always_comb
    begin
        state_next = state_reg;
        unique case (state_reg)
            MSD_ST_IDLE:
            begin
                if (start)
                    state_next = MSD_ST_WAIT;
            end
            MSD_ST_WAIT:
            begin
                if (finish)
                    state_next = MSD_ST_DONE;
            end
            MSD_ST_DONE:
            begin
                state_next = MSD_ST_IDLE;
            end
            default:
            begin
                state_next = MSD_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state_reg <= MSD_ST_IDLE;
            region_reg <= MSD_REG_ROM;
            is_xd_reg <= 1'b0;
            is_we_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            if (start)
            begin
                region_reg <= start_xd ? MSD_REG_EXT : region_now;
                is_xd_reg <= start_xd;
                is_we_reg <= start_prg ? prg_we_i : xd_we_i;
            end
        end
    end

    // ****************************************
    // Memory strobes and addresses
    // ****************************************
    logic prg_int_rom;
    logic prg_int_ram;
    logic prg_ext;

    assign prg_int_rom = start_prg & (region_now == MSD_REG_ROM);
    assign prg_int_ram = start_prg & (region_now == MSD_REG_RAM);
    assign prg_ext = start_prg & (region_now == MSD_REG_EXT);

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            prgaddr_o <= 16'h0000;
            prgdatao_o <= 8'h00;
            xaddr_o <= 24'h000000;
            xdatao_o <= 8'h00;
            prgromrd_o <= 1'b0;
            prgramrd_o <= 1'b0;
            prgramwr_o <= 1'b0;
            xprgrd_o <= 1'b0;
            xprgwr_o <= 1'b0;
            xramrd_o <= 1'b0;
            xramwr_o <= 1'b0;
        end
        else if (start)
        begin
            prgaddr_o <= prg_addr_i;                                      // R4 R14
            prgdatao_o <= prg_wdata_i;
            xaddr_o <= start_xd ? {data_pointer_extension_reg, xd_addr_i} // R6 R16
                                : {8'h00, prg_addr_i};
            xdatao_o <= start_xd ? xd_wdata_i : prg_wdata_i;
            prgromrd_o <= prg_int_rom & ~prg_we_i;                        // R1
            prgramrd_o <= prg_int_ram & ~prg_we_i;                        // R2
            prgramwr_o <= prg_int_ram & prg_we_i;                         // R11
            xprgrd_o <= prg_ext & ~prg_we_i;                              // R3
            xprgwr_o <= prg_ext & prg_we_i;                               // R11
            xramrd_o <= start_xd & ~xd_we_i;
            xramwr_o <= start_xd & xd_we_i;
        end
        else if (finish)
        begin
            prgromrd_o <= 1'b0;
            prgramrd_o <= 1'b0;
            prgramwr_o <= 1'b0;
            xprgrd_o <= 1'b0;
            xprgwr_o <= 1'b0;
            xramrd_o <= 1'b0;
            xramwr_o <= 1'b0;
        end
    end

    // ****************************************
    // Core handshake
    // ****************************************
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            acc_ack_o <= 1'b0;
            acc_rdata_o <= 8'h00;
            stall_o <= 1'b0;
        end
        else
        begin
            acc_ack_o <= finish;
            acc_rdata_o <= (finish & ~is_we_reg) ? rdata_sel : acc_rdata_o;
            stall_o <= start | ((state_reg == MSD_ST_WAIT) & ~finish);  // R8
        end
    end

    // ****************************************
    // Direct space: data RAM and special registers
    // ****************************************
    logic dir_low;
    logic user_reg;

    assign dir_low = (dir_addr_i < `MSD_SPECIAL_BASE);              // R5
    assign user_reg = ~dir_low & ~core_reg_hit_i;                   // R7

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ramaddr_o <= 8'h00;
            ramdatao_o <= 8'h00;
            ramoe_o <= 1'b0;
            ramwe_o <= 1'b0;
            sfraddr_o <= 7'h00;
            sfrdatao_o <= 8'h00;
            sfroe_o <= 1'b0;
            sfrwe_o <= 1'b0;
        end
        else
        begin
            ramaddr_o <= dir_addr_i;                                // R5
            ramdatao_o <= dir_wdata_i;
            ramoe_o <= dir_re_i & dir_low;
            ramwe_o <= dir_we_i & dir_low;
            sfraddr_o <= dir_addr_i[`MSD_SPECIAL_AW-1:0];           // R17
            sfrdatao_o <= dir_wdata_i;
            sfroe_o <= dir_re_i & user_reg;                         // R7 R17
            sfrwe_o <= dir_we_i & user_reg;                         // R7 R17
        end
    end

endmodule

`default_nettype wire

// file: sim/msd_props.sv
`timescale 1ns/1ps
`default_nettype none
module msd_props #(
    parameter bit PRG_SYNC = 1'b1,
    parameter bit FIXED_SIZE = 1'b0
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic [15:0] xd_addr_i,
    input wire logic acc_ack_o,
    input wire logic stall_o,
    input wire logic ready_i,
    input wire logic dir_re_i,
    input wire logic dir_we_i,
    input wire logic [7:0] dir_addr_i,
    input wire logic core_reg_hit_i,
    input wire logic prgromrd_o,
    input wire logic prgramrd_o,
    input wire logic xprgrd_o,
    input wire logic xramrd_o,
    input wire logic [23:0] xaddr_o,
    input wire logic [7:0] ramaddr_o,
    input wire logic ramoe_o,
    input wire logic [6:0] sfraddr_o,
    input wire logic sfroe_o,
    input wire logic sfrwe_o
);
    // ****************
    // Port relations
    // ****************
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_wb_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("bus request not acknowledged");
    a_wb_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("bus ack longer than one cycle");
    a_acc_done: assert property (acc_ack_o |-> !stall_o ##1 !acc_ack_o)
        else $error("access ack with stall or repeated");
    a_ready_hold: assert property ((xramrd_o || xprgrd_o) && !ready_i |=> !acc_ack_o)
        else $error("access finished while memory not ready");
    a_ram_route: assert property (dir_re_i && !dir_addr_i[7]
        |=> ramoe_o && !sfroe_o && ramaddr_o == $past(dir_addr_i))
        else $error("low direct read not sent to data ram");
    a_user_route: assert property (dir_re_i && dir_addr_i[7] && !core_reg_hit_i
        |=> sfroe_o && !ramoe_o && sfraddr_o == $past(dir_addr_i[6:0]))
        else $error("upper direct read not sent to user registers");
    a_core_skip: assert property ((dir_re_i || dir_we_i) && core_reg_hit_i && dir_addr_i[7]
        |=> !sfroe_o && !sfrwe_o)
        else $error("user register strobe on core register hit");
    a_xaddr_low: assert property ($rose(xramrd_o) |-> xaddr_o[15:0] == $past(xd_addr_i))
        else $error("external data address wrong");
    a_strobe_one: assert property (prgromrd_o |-> !prgramrd_o && !xprgrd_o)
        else $error("more than one program read strobe");
endmodule

bind msd_decoder msd_props #(.PRG_SYNC(PRG_SYNC), .FIXED_SIZE(FIXED_SIZE)) u_msd_props (
    .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .xd_addr_i, .acc_ack_o, .stall_o,
    .ready_i, .dir_re_i, .dir_we_i, .dir_addr_i, .core_reg_hit_i, .prgromrd_o, .prgramrd_o,
    .xprgrd_o, .xramrd_o, .xaddr_o, .ramaddr_o, .ramoe_o, .sfraddr_o, .sfroe_o, .sfrwe_o
);
`default_nettype wire

// file: sim/msd_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module msd_mem_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic slow_i,
    input wire logic [15:0] prgaddr_i,
    input wire logic [23:0] xaddr_i,
    input wire logic romrd_i,
    input wire logic ramrd_i,
    input wire logic xrd_i,
    input wire logic xact_i,
    output logic [7:0] rom_o,
    output logic [7:0] ram_o,
    output logic [7:0] xdat_o,
    output logic ready_o
);
    // ****************
    // Memories
    // ****************
    logic [2:0] wait_reg;
    // Synchronous program memories, toggling when not read
    always_ff @(posedge clk_i)
    begin
        rom_o <= rst_i ? 8'h00 : (romrd_i ? prgaddr_i[7:0] ^ 8'h3c : ~rom_o);
        ram_o <= rst_i ? 8'h00 : (ramrd_i ? prgaddr_i[7:0] ^ 8'hc3 : ~ram_o);
        wait_reg <= (rst_i || !xact_i) ? 3'h0 : wait_reg + {2'h0, wait_reg != 3'h6};
    end
    assign ready_o = !slow_i || wait_reg == 3'h6;
    assign xdat_o = xrd_i ? xaddr_i[7:0] ^ xaddr_i[23:16] ^ 8'h99 : ~xaddr_i[7:0];
endmodule
`default_nettype wire

// file: sim/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    // ****************
    // Stimulus and checks
    // ****************
    logic clk_i = 1'b0, rst_i = 1'b1, slow = 1'b0;
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, dir_re_i = 1'b0, dir_we_i = 1'b0;
    logic prg_req_i = 1'b0, prg_we_i = 1'b0, xd_req_i = 1'b0, xd_we_i = 1'b0;
    logic core_reg_hit_i = 1'b0, ready_i, wb_ack_o, acc_ack_o, stall_o, prgromrd_o, prgramrd_o;
    logic prgramwr_o, xprgrd_o, xprgwr_o, xramrd_o, xramwr_o, ramoe_o, ramwe_o, sfroe_o, sfrwe_o;
    logic [7:0] wb_adr_i = '0, prg_wdata_i = '0, xd_wdata_i = '0, dir_addr_i = '0;
    logic [7:0] dir_wdata_i = '0, rnd = 8'h44, dp, prgromdata_i, prgramdata_i, xdatai_i;
    logic [7:0] acc_rdata_o, ramaddr_o, a, pdo, xdo, rdo, sdo;
    logic [3:0] wb_sel_i = 4'hf;
    logic [31:0] wb_dat_i = '0, wb_dat_o;
    logic [15:0] prg_addr_i = '0, xd_addr_i = '0, prgaddr_o, xa;
    logic [2:0] rom_size_code_i = 3'h1, ram_size_code_i = 3'h1;
    logic [6:0] sfraddr_o, msk;
    logic [23:0] xaddr_o;
    logic [31:0] exp_q [$];
    logic [15:0] pa [9] = '{16'h0000, 16'h03ff, 16'h0400, 16'hfbff, 16'hfc00, 16'hffff,
        16'hffff, 16'h0400, 16'h0000};
    logic [7:0] pd [6] = '{8'h3c, 8'hc3, 8'h99, 8'h66, 8'hc3, 8'h3c};
    logic [6:0] pm [9] = '{7'h40, 7'h40, 7'h08, 7'h08, 7'h20, 7'h20, 7'h10, 7'h04, 7'h00};
    int err_count = 0, num_checks = 0, lat, fl;

    msd_decoder u_msd_decoder (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
        .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .prg_req_i, .prg_we_i, .prg_addr_i,
        .prg_wdata_i, .xd_req_i, .xd_we_i, .xd_addr_i, .xd_wdata_i, .acc_ack_o, .acc_rdata_o,
        .stall_o, .dir_re_i, .dir_we_i, .dir_addr_i, .dir_wdata_i, .core_reg_hit_i,
        .rom_size_code_i, .ram_size_code_i, .prgromdata_i, .prgramdata_i, .xdatai_i, .ready_i,
        .prgaddr_o, .prgdatao_o(pdo), .prgromrd_o, .prgramrd_o, .prgramwr_o, .xaddr_o,
        .xdatao_o(xdo), .xprgrd_o, .xprgwr_o, .xramrd_o, .xramwr_o, .ramaddr_o, .ramdatao_o(rdo),
        .ramoe_o, .ramwe_o, .sfraddr_o, .sfrdatao_o(sdo), .sfroe_o, .sfrwe_o);
    msd_mem_model u_msd_mem_model (.clk_i, .rst_i, .slow_i(slow), .prgaddr_i(prgaddr_o),
        .xaddr_i(xaddr_o), .romrd_i(prgromrd_o), .ramrd_i(prgramrd_o),
        .xrd_i(xprgrd_o | xramrd_o), .xact_i(xprgrd_o | xramrd_o | xprgwr_o | xramwr_o),
        .rom_o(prgromdata_i), .ram_o(prgramdata_i), .xdat_o(xdatai_i), .ready_o(ready_i));

    always #12.5 clk_i = ~clk_i;

    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic wb(input logic w, input logic [7:0] ad, input logic [31:0] d);
        if (!w)
            exp_q.push_back(d);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= ad;
        wb_dat_i <= d;
        do @(negedge clk_i); while (!wb_ack_o);
        @(posedge clk_i);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic acc(input logic p, input logic w, input logic [15:0] ad, input logic [7:0] e);
        if (!w)
            exp_q.push_back({24'h0, e});
        prg_req_i <= p;
        xd_req_i <= !p;
        prg_we_i <= w;
        xd_we_i <= w;
        prg_addr_i <= ad;
        xd_addr_i <= ad;
        prg_wdata_i <= rnd;
        xd_wdata_i <= rnd;
        msk = '0;
        lat = 0;
        do
        begin
            @(posedge clk_i);
            @(negedge clk_i);
            lat++;
            msk |= {prgromrd_o, prgramrd_o, prgramwr_o, xprgrd_o, xprgwr_o, xramrd_o, xramwr_o};
            if (lat == 1)
                chk(stall_o, 1'b1);
        end
        while (!acc_ack_o);
        chk(stall_o, 1'b0);
        @(posedge clk_i);
        prg_req_i <= 1'b0;
        xd_req_i <= 1'b0;
        @(posedge clk_i);
    endtask

    // Read results are matched against the oldest note
    always @(negedge clk_i)
        if ((wb_ack_o && !wb_we_i) || (acc_ack_o && !prg_we_i))
            chk(wb_ack_o ? wb_dat_o : {24'h0, acc_rdata_o}, exp_q.pop_front());

    initial
    begin
        repeat (20000) @(posedge clk_i);
        err_count++;
        tally_and_finish();
    end

    initial
    begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        wb(1'b0, 8'h00, 32'h0);
        wb(1'b0, 8'h04, 32'h0);
        wb(1'b0, 8'h0c, 32'h0);
        wb(1'b0, 8'h08, 32'h12);
        wb(1'b1, 8'h00, 32'h21);
        wb(1'b0, 8'h00, 32'h21);
        rnd = lfsr(rnd);
        dp = rnd;
        wb(1'b1, 8'h04, {24'h0, dp});
        wb(1'b0, 8'h04, {24'h0, dp});
        wb_sel_i <= 4'he;
        wb(1'b1, 8'h04, 32'h0);
        wb_sel_i <= 4'hf;
        wb(1'b0, 8'h04, {24'h0, dp});
        $display("test registers done");
        for (int i = 0; i < 9; i++)
        begin
            acc(1'b1, i > 5, pa[i], i > 5 ? 8'h00 : pd[i % 6]);
            chk(msk, pm[i]);
            chk(prgaddr_o, pa[i]);
            if (i < 6)
                chk(lat, pm[i] == 7'h08 ? 32'd3 : 32'd4);
            else
                chk({xdo, pdo}, {rnd, rnd});
        end
        rom_size_code_i <= 3'h7;
        ram_size_code_i <= 3'h7;
        acc(1'b1, 1'b0, 16'hffff, 8'hc3);
        chk(msk, 7'h40);
        rom_size_code_i <= 3'h0;
        ram_size_code_i <= 3'h0;
        acc(1'b1, 1'b0, 16'h0000, 8'h99);
        chk(msk, 7'h08);
        $display("test program space done");
        rnd = lfsr(rnd);
        xa = {rnd, ~rnd};
        acc(1'b0, 1'b0, xa, ~rnd ^ dp ^ 8'h99);
        chk(msk, 7'h02);
        chk(xaddr_o, {dp, xa});
        fl = lat;
        chk(fl, 32'd4);
        slow <= 1'b1;
        acc(1'b0, 1'b0, xa, ~rnd ^ dp ^ 8'h99);
        chk(lat > fl, 1'b1);
        acc(1'b0, 1'b1, xa, 8'h00);
        chk(msk, 7'h01);
        chk(xdo, rnd);
        slow <= 1'b0;
        $display("test external data done");
        for (int i = 0; i < 16; i++)
        begin
            a = i[1] ? (i[0] ? 8'hff : 8'h80) : (i[0] ? 8'h7f : 8'h00);
            rnd = lfsr(rnd);
            dir_addr_i <= a;
            core_reg_hit_i <= i[2];
            dir_re_i <= !i[3];
            dir_we_i <= i[3];
            dir_wdata_i <= rnd;
            @(posedge clk_i);
            @(negedge clk_i);
            chk({ramoe_o, ramwe_o, sfroe_o, sfrwe_o}, {!a[7] && !i[3], !a[7] && i[3],
                a[7] && !i[2] && !i[3], a[7] && !i[2] && i[3]});
            chk({rdo, sdo}, {rnd, rnd});
            if (!a[7])
                chk(ramaddr_o, a);
            else if (!i[2])
                chk(sfraddr_o, a[6:0]);
            @(posedge clk_i);
        end
        $display("test direct space done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
